// ---- common/ocu_defines.vh ----
`ifndef OCU_DEFINES_VH
`define OCU_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OCU_ADDR_CTRL      8'h00
`define OCU_ADDR_PRIMARY   8'h10
`define OCU_ADDR_SECONDARY 8'h20
`define OCU_ADDR_INT_STAT  8'h30
`define OCU_ADDR_INT_CLR   8'h34
`define OCU_ADDR_INT_EN    8'h38

// ----------------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------------
`define OCU_BIT_ON         15
`define OCU_BIT_IDLE_STOP  13
`define OCU_BIT_WIDE       5
`define OCU_BIT_FAULT      4
`define OCU_BIT_TSEL       3
`define OCU_MODE_HI        2
`define OCU_MODE_LO        0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OCU_CTRL_RESET     32'h0000_0000
`define OCU_CMP_RESET      32'h0000_0000
`define OCU_INT_RESET      3'h0

// ----------------------------------------------------------------------------
// Compare modes
// ----------------------------------------------------------------------------
`define OCU_MODE_OFF       3'h0
`define OCU_MODE_SET_HIGH  3'h1
`define OCU_MODE_SET_LOW   3'h2
`define OCU_MODE_TOGGLE    3'h3
`define OCU_MODE_ONE_PULSE 3'h4
`define OCU_MODE_PULSES    3'h5
`define OCU_MODE_PWM       3'h6
`define OCU_MODE_PWM_FAULT 3'h7

// ----------------------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------------------
`define OCU_EVT_PRIMARY    0
`define OCU_EVT_SECONDARY  1
`define OCU_EVT_FAULT      2
`define OCU_EVT_W          3

`endif

// ---- dv/ocu_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------
// Port checker
// ----------------------------------
module ocu_chk #(
  parameter AW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pslverr,
  input wire logic [31:0]   first_timebase_count,
  input wire logic [31:0]   second_timebase_count,
  input wire logic          idle_mode,
  input wire logic          fault_n,
  input wire logic          compare_output_pin,
  input wire logic          compare_output_oe
);
  logic [31:0] ctl;
  logic [31:0] pri;
  logic [31:0] cnt;
  logic        eq;
  logic        wr;
  logic        bad;
  // Software copy of control and primary; full strobes assumed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 32'h0000_0000;
      pri <= 32'h0000_0000;
    end else begin
      if (wr && paddr == AW'(8'h00)) ctl <= pwdata;
      if (wr && paddr == AW'(8'h10)) pri <= pwdata;
    end
  end
  // Narrow mode looks at the low half only
  assign wr  = psel && penable && pwrite;
  assign cnt = ctl[3] ? second_timebase_count : first_timebase_count;
  assign eq  = ctl[5] ? cnt == pri : cnt[15:0] == pri[15:0];
  assign bad = !(paddr inside {AW'(8'h00), AW'(8'h10), AW'(8'h20), AW'(8'h30), AW'(8'h34),
                               AW'(8'h38)});
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Idle stop with the processor idle masks every match
  sequence s_hit(logic [2:0] m);
    ctl[15] && ctl[2:0] == m && $rose(eq) && $stable(ctl) && !(ctl[13] && idle_mode);
  endsequence
  property p_off; !ctl[15] |=> !compare_output_pin; endproperty
  a_off: assert property (p_off) else $error("pin high while off");
  property p_oe; !ctl[15] || ctl[2:0] == 3'h0 |-> !compare_output_oe; endproperty
  a_oe: assert property (p_oe) else $error("pin driven while inactive");
  property p_set_hi; s_hit(3'h1) |-> ##[1:3] compare_output_pin; endproperty
  a_set_hi: assert property (p_set_hi) else $error("match left pin low");
  property p_set_lo; s_hit(3'h2) |-> ##[1:3] !compare_output_pin; endproperty
  a_set_lo: assert property (p_set_lo) else $error("match left pin high");
  property p_flt;
    ctl[15] && ctl[2:0] == 3'h7 && !fault_n |-> ##[1:2] !compare_output_oe;
  endproperty
  a_flt: assert property (p_flt) else $error("fault did not stop output");
  property p_pwm; ctl[15] && ctl[2:0] == 3'h6 && $stable(ctl) |-> compare_output_oe; endproperty
  a_pwm: assert property (p_pwm) else $error("output dropped in plain pwm");
  property p_idle;
    ctl[15] && ctl[13] && idle_mode && $past(idle_mode) && $stable(ctl)
      |-> $stable(compare_output_pin);
  endproperty
  a_idle: assert property (p_idle) else $error("pin moved while stopped");
  property p_err; psel && penable |-> pslverr == bad; endproperty
  a_err: assert property (p_err) else $error("error response mismatch");
  c_flt: cover property (ctl[2:0] == 3'h7 && !fault_n);
  c_bad: cover property (psel && penable && bad);
  c_tgl: cover property (ctl[2:0] == 3'h3 && $rose(eq));
endmodule
bind ocu_top ocu_chk #(.AW(AW)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .first_timebase_count, .second_timebase_count, .idle_mode, .fault_n,
  .compare_output_pin, .compare_output_oe
);
`default_nettype wire

// ---- dv/ocu_load.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------
// Pin load and fault source
// ----------------------------------
module ocu_load (
  input  wire logic       pclk,
  input  wire logic       clr,
  input  wire logic       fault_req,
  input  wire logic       compare_output_pin,
  input  wire logic       compare_output_oe,
  output var  logic       fault_n,
  output var  logic       line,
  output var  logic [7:0] rises,
  output var  logic [7:0] width
);
  logic       last;
  logic [7:0] run;
  // Pull-up on fault, pull-down on the pin: no stale level
  assign fault_n = !fault_req;
  assign line    = compare_output_oe ? compare_output_pin : 1'b0;
  // Count pulses and measure the last high time
  always @(posedge pclk) begin
    last <= line;
    run  <= line ? run + 8'h01 : 8'h00;
    if (clr) begin
      rises <= 8'h00;
      width <= 8'h00;
    end else begin
      if (line && !last) rises <= rises + 8'h01;
      if (!line && last) width <= run;
    end
  end
endmodule
`default_nettype wire

// ---- dv/output_compare_unit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module output_compare_unit_tb_top;
  // ----------------------------------
  // Bench
  // ----------------------------------
  localparam logic [31:0] IDLE_CNT = 32'h0000_7777;
  logic        pclk, fault_n, line, pready, pslverr, pin, oe, irq, rerr, ts, wd;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        idle_mode = 1'b0, fault_req = 1'b0, clr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  rises, width;
  logic [2:0]  m;
  logic [31:0] pwdata = 32'h0000_0000, c1 = IDLE_CNT, c2 = IDLE_CNT;
  logic [31:0] prdata, rdat;
  int          failures = 0, tests_run = 0, cyc = 0;
  ocu_top #(.AW(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_timebase_count(c1), .second_timebase_count(c2),
    .idle_mode(idle_mode), .fault_n(fault_n), .compare_output_pin(pin),
    .compare_output_oe(oe), .irq(irq)
  );
  ocu_load i_load (
    .pclk(pclk), .clr(clr), .fault_req(fault_req), .compare_output_pin(pin),
    .compare_output_oe(oe), .fault_n(fault_n), .line(line), .rises(rises), .width(width)
  );
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One transfer, then an idle cycle so strobes never repeat in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rdat, exp);
  endtask
  task automatic cfg(input logic [31:0] d);
    apb(1'b1, 8'h00, d);
    repeat (2) @(posedge pclk);
  endtask
  // One-cycle match on one timer; pin answers two edges later
  task automatic hit(input logic sel, input logic [31:0] v);
    if (sel) c2 <= v;
    else c1 <= v;
    @(posedge pclk);
    c1 <= IDLE_CNT;
    c2 <= IDLE_CNT;
    repeat (4) @(posedge pclk);
  endtask
  task automatic sweep(input int n);
    repeat (n) for (int i = 0; i < 40; i++) begin
      c1 <= 32'(i);
      @(posedge pclk);
    end
    c1 <= IDLE_CNT;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("control reset", 8'h00, 32'h0000_0000);
    rd("secondary reset", 8'h20, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'hFFFF_5FD0);
    rd("unused bits", 8'h00, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_A02B);
    rd("control fields", 8'h00, 32'h0000_A02B);
    apb(1'b1, 8'h44, 32'hFFFF_FFFF);
    check("error response", rerr, 1'b1);
    rd("unmapped", 8'h44, 32'h0000_0000);
    cfg(32'h0000_0000);
    // Set and clear modes over both timers and both widths
    for (int k = 0; k < 8; k++) begin
      m = (k < 4) ? 3'h1 : 3'h2;
      ts = k[0];
      wd = k[1];
      apb(1'b1, 8'h10, 32'h0001_0050);
      cfg({16'h0000, 8'h80, 2'b00, wd, 1'b0, ts, m});
      check("entry level", line, m == 3'h2);
      hit(!ts, 32'h0001_0050);
      check("other timer", line, m == 3'h2);
      hit(ts, 32'h0000_0050);
      check("narrow match", line, (m == 3'h1) ^ wd);
      hit(ts, 32'h0001_0050);
      check("full match", line, m == 3'h1);
      cfg(32'h0000_0000);
      check("off level", line, 1'b0);
    end
    // Toggle, interrupt and idle stop
    apb(1'b1, 8'h38, 32'h0000_0001);
    cfg(32'h0000_A003);
    hit(1'b0, 32'h0000_0050);
    check("toggle up", line, 1'b1);
    hit(1'b0, 32'h0000_0050);
    check("toggle down", line, 1'b0);
    check("irq raised", irq, 1'b1);
    rd("status", 8'h30, 32'h0000_0001);
    apb(1'b1, 8'h38, 32'h0000_0000);
    check("irq masked", irq, 1'b0);
    apb(1'b1, 8'h34, 32'h0000_0001);
    rd("status cleared", 8'h30, 32'h0000_0000);
    idle_mode <= 1'b1;
    hit(1'b0, 32'h0000_0050);
    check("idle frozen", line, 1'b0);
    cfg(32'h0000_8003);
    hit(1'b0, 32'h0000_0050);
    check("idle running", line, 1'b1);
    idle_mode <= 1'b0;
    cfg(32'h0000_0000);
    // Pulse and pwm modes, fault held on in plain pwm
    apb(1'b1, 8'h10, 32'h0000_000A);
    apb(1'b1, 8'h20, 32'h0000_0014);
    for (int k = 4; k < 8; k++) begin
      fault_req <= (k == 6);
      clr <= 1'b1;
      cfg({16'h0000, 8'h80, 5'h00, 3'(k)});
      clr <= 1'b0;
      check("pulse entry", line, 1'b0);
      sweep(2);
      check("pulse count", rises, (k == 4) ? 1 : 2);
      check("pulse width", width, 32'd10);
    end
    apb(1'b1, 8'h34, 32'h0000_0007);
    fault_req <= 1'b1;
    repeat (3) @(posedge pclk);
    check("fault stops drive", oe, 1'b0);
    rd("fault flag", 8'h00, 32'h0000_8017);
    rd("fault event", 8'h30, 32'h0000_0004);
    cfg(32'h0000_8007);
    rd("flag kept", 8'h00, 32'h0000_8017);
    fault_req <= 1'b0;
    sweep(1);
    rd("flag cleared", 8'h00, 32'h0000_8007);
    check("pwm restart", rises, 32'd3);
    fault_req <= 1'b1;
    repeat (3) @(posedge pclk);
    // Fault input released but the flag still stands when the mode changes
    fault_req <= 1'b0;
    cfg(32'h0000_8006);
    rd("flag other mode", 8'h00, 32'h0000_8006);
    cfg(32'h0000_8000);
    check("mode zero", line | oe, 1'b0);
    results();
  end
endmodule
`default_nettype wire

// ---- hdl/ocu_irq.v ----
`timescale 1ns/1ps
`default_nettype none

module ocu_irq #(
  parameter W = 3
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] event_pulse,
  input  wire         clear_write,
  input  wire         enable_write,
  input  wire [W-1:0] write_data,
  output reg  [W-1:0] status,
  output reg  [W-1:0] enable,
  output wire         irq
);

  // --------------------------------------------------------------------------
  // Sticky status and enable
  // --------------------------------------------------------------------------
  // A new event wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= {W{1'b0}};
      enable <= {W{1'b0}};
    end else begin
      status <= (status & ~(clear_write ? write_data : {W{1'b0}})) | event_pulse;
      if (enable_write) begin
        enable <= write_data;
      end
    end
  end

  // Level output while any enabled bit stands
  assign irq = |(status & enable);

endmodule

`default_nettype wire

// ---- hdl/ocu_match.v ----
`timescale 1ns/1ps
`default_nettype none

module ocu_match (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [31:0] first_timebase_count,
  input  wire [31:0] second_timebase_count,
  input  wire        timebase_select,
  input  wire        wide_compare_select,
  input  wire [31:0] primary_compare_value,
  input  wire [31:0] secondary_compare_value,
  output reg         primary_hit,
  output reg         secondary_hit
);

  // --------------------------------------------------------------------------
  // Width fitting
  // --------------------------------------------------------------------------
  // Narrow mode keeps only the low half of any operand
  function [31:0] fit;
    input [31:0] v;
    input        wide;
    begin
      fit = wide ? v : {16'h0000, v[15:0]};
    end
  endfunction

  // Timebase choice and operand width
  wire [31:0] count = fit(timebase_select ? second_timebase_count
                                          : first_timebase_count,
                          wide_compare_select);
  wire        eq_pri = (count == fit(primary_compare_value,
                                     wide_compare_select));
  wire        eq_sec = (count == fit(secondary_compare_value,
                                     wide_compare_select));
  reg         eq_pri_q;
  reg         eq_sec_q;

  // Edge of equality, so a stalled timer gives one hit, not a stream
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_pri_q      <= 1'b0;
      eq_sec_q      <= 1'b0;
      primary_hit   <= 1'b0;
      secondary_hit <= 1'b0;
    end else begin
      eq_pri_q      <= eq_pri;
      eq_sec_q      <= eq_sec;
      primary_hit   <= eq_pri & ~eq_pri_q;
      secondary_hit <= eq_sec & ~eq_sec_q;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/ocu_top.v ----
// Summary of operation
// - Bit 15 turns the unit on
// - Bit 13 stops the unit in idle
// - Bit 5 picks 32 or 16 bit compare
// - Bit 4 fault flag, hardware only
// - Fault flag reads zero outside mode 7
// - Bit 3 picks second or first timebase
// - Mode 7 is PWM with fault input
// - Mode 6 is PWM, fault ignored
// - Mode 5 starts low, pulses continuously
// - Mode 4 starts low, one pulse only
// - Mode 3 toggles on each match
// - Mode 2 starts high, match drives low
// - Mode 1 starts low, match drives high
// - Mode 0 disables output, unit stays powered
// - Unused control bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "ocu_defines.vh"

module ocu_top #(
  parameter AW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire [31:0]   first_timebase_count,
  input  wire [31:0]   second_timebase_count,
  input  wire          idle_mode,
  input  wire          fault_n,
  output reg           compare_output_pin,
  output wire          compare_output_oe,
  output wire          irq
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Byte-lane merge of a write into a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // Address compare on the low byte
  function hit;
    input [AW-1:0] a;
    input [7:0]    ofs;
    begin
      hit = (a[7:0] == ofs) && (a[AW-1:0] >> 8 == {AW{1'b0}});
    end
  endfunction

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  wire setup_phase  = psel & ~penable;
  wire access_phase = psel & penable;
  wire wr           = access_phase & pwrite;

  wire sel_ctrl = hit(paddr, `OCU_ADDR_CTRL);
  wire sel_pri  = hit(paddr, `OCU_ADDR_PRIMARY);
  wire sel_sec  = hit(paddr, `OCU_ADDR_SECONDARY);
  wire sel_ist  = hit(paddr, `OCU_ADDR_INT_STAT);
  wire sel_icl  = hit(paddr, `OCU_ADDR_INT_CLR);
  wire sel_ien  = hit(paddr, `OCU_ADDR_INT_EN);
  wire mapped   = sel_ctrl | sel_pri | sel_sec | sel_ist | sel_icl | sel_ien;

  assign pready  = 1'b1;
  assign pslverr = access_phase & ~mapped;

  // --------------------------------------------------------------------------
  // Control and compare registers
  // --------------------------------------------------------------------------
  reg         ctl_on;
  reg         idle_stop;
  reg         wide_compare_select;
  reg         timebase_select;
  reg  [2:0]  compare_mode_select;
  reg  [31:0] primary_compare_value;
  reg  [31:0] secondary_compare_value;
  reg         fault_flag;

  // Stored control word; only implemented bits are kept
  wire [31:0] ctrl_now = {16'h0000, ctl_on, 1'b0, idle_stop, 7'h00,
                          wide_compare_select, 1'b0, timebase_select,
                          compare_mode_select};
  wire [31:0] ctrl_new = merge(ctrl_now, pwdata, pstrb);

  // Writes; the fault bit is not writable and unused bits are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_on                  <= 1'b0;
      idle_stop               <= 1'b0;
      wide_compare_select     <= 1'b0;
      timebase_select         <= 1'b0;
      compare_mode_select     <= `OCU_MODE_OFF;
      primary_compare_value   <= `OCU_CMP_RESET;
      secondary_compare_value <= `OCU_CMP_RESET;
    end else begin
      if (wr && sel_ctrl) begin
        ctl_on              <= ctrl_new[`OCU_BIT_ON];
        idle_stop           <= ctrl_new[`OCU_BIT_IDLE_STOP];
        wide_compare_select <= ctrl_new[`OCU_BIT_WIDE];
        timebase_select     <= ctrl_new[`OCU_BIT_TSEL];
        compare_mode_select <= ctrl_new[`OCU_MODE_HI:`OCU_MODE_LO];
      end
      if (wr && sel_pri) begin
        primary_compare_value <= merge(primary_compare_value, pwdata, pstrb);
      end
      if (wr && sel_sec) begin
        secondary_compare_value <= merge(secondary_compare_value, pwdata, pstrb);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Match detection
  // --------------------------------------------------------------------------
  wire primary_hit;
  wire secondary_hit;

  ocu_match u_match (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .first_timebase_count    (first_timebase_count),
    .second_timebase_count   (second_timebase_count),
    .timebase_select         (timebase_select),
    .wide_compare_select     (wide_compare_select),
    .primary_compare_value   (primary_compare_value),
    .secondary_compare_value (secondary_compare_value),
    .primary_hit             (primary_hit),
    .secondary_hit           (secondary_hit)
  );

  // --------------------------------------------------------------------------
  // Run and mode entry
  // --------------------------------------------------------------------------
  // Idle stop freezes the output where it stands instead of resetting it
  wire       run      = ctl_on & ~(idle_stop & idle_mode);
  wire       is_pwm   = compare_mode_select[2] & compare_mode_select[1];
  wire       flt_mode = (compare_mode_select == `OCU_MODE_PWM_FAULT);
  wire       flt_in   = flt_mode & ~fault_n;
  reg  [2:0] mode_q;
  reg        on_q;
  wire       entry    = ctl_on & (~on_q | (mode_q != compare_mode_select));

  // Previous mode and enable, for entry detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `OCU_MODE_OFF;
      on_q   <= 1'b0;
    end else begin
      mode_q <= compare_mode_select;
      on_q   <= ctl_on;
    end
  end

  // --------------------------------------------------------------------------
  // Output sequencer
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_RISE = 3'h1;
  localparam ST_FALL = 3'h2;
  localparam ST_DONE = 3'h3;
  localparam ST_HALT = 3'h4;

  reg  [2:0] state;
  reg  [2:0] next_state;
  reg        next_pin;
  reg        next_fault;
  wire       p_hit = run & primary_hit;
  wire       s_hit = run & secondary_hit;

  // Next output level and sequence state
  always @* begin
    next_state = state;
    next_pin   = compare_output_pin;
    next_fault = fault_flag;
    if (!ctl_on) begin
      next_state = ST_IDLE;
      next_pin   = 1'b0;
      next_fault = 1'b0;
    end else if (entry) begin
      next_fault = 1'b0;
      case (compare_mode_select)
        `OCU_MODE_SET_LOW: begin
          next_pin   = 1'b1;
          next_state = ST_RISE;
        end
        `OCU_MODE_TOGGLE: begin
          next_state = ST_RISE;
        end
        `OCU_MODE_OFF: begin
          next_pin   = 1'b0;
          next_state = ST_IDLE;
        end
        default: begin
          next_pin   = 1'b0;
          next_state = ST_RISE;
        end
      endcase
    end else if (run) begin
      case (compare_mode_select)
        `OCU_MODE_SET_HIGH: begin
          if (p_hit) begin
            next_pin = 1'b1;
          end
        end
        `OCU_MODE_SET_LOW: begin
          if (p_hit) begin
            next_pin = 1'b0;
          end
        end
        `OCU_MODE_TOGGLE: begin
          if (p_hit) begin
            next_pin = ~compare_output_pin;
          end
        end
        `OCU_MODE_ONE_PULSE,
        `OCU_MODE_PULSES: begin
          if (state == ST_RISE && p_hit) begin
            next_pin   = 1'b1;
            next_state = ST_FALL;
          end else if (state == ST_FALL && s_hit) begin
            next_pin   = 1'b0;
            next_state = compare_mode_select[0] ? ST_RISE : ST_DONE;
          end
        end
        `OCU_MODE_PWM,
        `OCU_MODE_PWM_FAULT: begin
          if (flt_in) begin
            next_pin   = 1'b0;
            next_fault = 1'b1;
            next_state = ST_HALT;
          end else if (state == ST_HALT) begin
            if (p_hit) begin
              next_fault = 1'b0;
              next_pin   = 1'b1;
              next_state = ST_FALL;
            end
          end else if (p_hit) begin
            next_pin   = 1'b1;
            next_state = ST_FALL;
          end else if (s_hit) begin
            next_pin   = 1'b0;
            next_state = ST_RISE;
          end
        end
        default: begin
          next_pin   = 1'b0;
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer state, output pin and fault flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= ST_IDLE;
      compare_output_pin <= 1'b0;
      fault_flag         <= 1'b0;
    end else begin
      state              <= next_state;
      compare_output_pin <= next_pin;
      fault_flag         <= next_fault & flt_mode;
    end
  end

  // Pin released while off, in mode 0, or while a fault holds it
  assign compare_output_oe = ctl_on & (compare_mode_select != `OCU_MODE_OFF)
                             & ~(flt_mode & fault_flag);

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  wire [`OCU_EVT_W-1:0] int_status;
  wire [`OCU_EVT_W-1:0] int_enable;
  wire [`OCU_EVT_W-1:0] events;

  assign events[`OCU_EVT_PRIMARY]   = p_hit & (compare_mode_select != `OCU_MODE_OFF);
  assign events[`OCU_EVT_SECONDARY] = s_hit & compare_mode_select[2];
  assign events[`OCU_EVT_FAULT]     = next_fault & ~fault_flag & flt_mode & ctl_on;

  ocu_irq #(
    .W (`OCU_EVT_W)
  ) u_irq (
    .pclk         (pclk),
    .presetn      (presetn),
    .event_pulse  (events),
    .clear_write  (wr & sel_icl),
    .enable_write (wr & sel_ien),
    .write_data   (pwdata[`OCU_EVT_W-1:0]),
    .status       (int_status),
    .enable       (int_enable),
    .irq          (irq)
  );

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Captured in the setup cycle so prdata is a flop in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      if (sel_ctrl) begin
        prdata <= ctrl_now | {27'h0, fault_flag & flt_mode, 4'h0};
      end else if (sel_pri) begin
        prdata <= primary_compare_value;
      end else if (sel_sec) begin
        prdata <= secondary_compare_value;
      end else if (sel_ist) begin
        prdata <= {29'h0, int_status};
      end else if (sel_ien) begin
        prdata <= {29'h0, int_enable};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire
